//--- pkg/lbsp_pkg.sv
// Constants shared by the local bus slave port and its helpers.
// Assumes a 32-bit address bus whose bit 31 is the most significant.
package lbsp_pkg;

    localparam int ADDR_WIDTH = 32;
    localparam int DATA_WIDTH = 64;
    localparam int SIZE_WIDTH = 3;
    localparam int TYPE_WIDTH = 5;
    localparam int DECODE_WIDTH = 3;
    localparam logic [DECODE_WIDTH-1:0] DECODE_MATCH = 3'h1;
    localparam int BURST_BEATS = 4;
    localparam int BEAT_WIDTH = 2;
    localparam int BEAT_LSB = 3;

    typedef enum logic [3:0] {
        PHASE_IDLE    = 4'h1,
        PHASE_BEAT    = 4'h2,
        PHASE_ACK     = 4'h4,
        PHASE_RELEASE = 4'h8
    } lbsp_phase_type;

endpackage

//--- src/lbsp_claim.sv
// Claim decoder: raises the claim sideband for cycles in the decode window.
// Assumes bus inputs are synchronous to clock and reset is already synced.
`timescale 1ns/10ps
module lbsp_claim (
    input  wire logic                               clock,          // Bus clock.
    input  wire logic                               rst_sync_n,     // Synced reset.
    input  wire logic                               transfer_start_n, // Start.
    input  wire logic [lbsp_pkg::DECODE_WIDTH-1:0]  addr_top,       // Top bits.
    input  wire logic                               address_ack_n,  // Addr ack.
    output logic                                    local_slave_n   // Claim.
);
    import lbsp_pkg::*;

    logic claim_reg;

    // ------------------------------------------------------------------
    // Claim flop
    // ------------------------------------------------------------------
    // The claim stays up until the bridge acknowledges the address.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            claim_reg <= 1'b0;
        end else begin
            claim_reg <= (!transfer_start_n && addr_top == DECODE_MATCH)
                      || (claim_reg && address_ack_n);
        end
    end

    // The claim is driven alone, so it is a forcing level at all times.
    assign local_slave_n = !claim_reg;

endmodule

//--- src/lbsp_tenure_hold.sv
// Holding register for the most recent address tenure.
// Assumes one address tenure at most is pending behind a data tenure.
`timescale 1ns/10ps
module lbsp_tenure_hold (
    input  wire logic                             clock,           // Bus clock.
    input  wire logic                             rst_sync_n,      // Synced reset.
    input  wire logic                             transfer_start_n, // Start.
    input  wire logic [lbsp_pkg::ADDR_WIDTH-1:0]  addr,            // Address.
    input  wire logic [lbsp_pkg::SIZE_WIDTH-1:0]  transfer_size,   // Size.
    input  wire logic [lbsp_pkg::TYPE_WIDTH-1:0]  transfer_type,   // Type.
    input  wire logic                             transfer_burst_n, // Burst.
    output logic [lbsp_pkg::ADDR_WIDTH-1:0]       hold_addr,       // Held addr.
    output logic [lbsp_pkg::SIZE_WIDTH-1:0]       hold_size,       // Held size.
    output logic [lbsp_pkg::TYPE_WIDTH-1:0]       hold_type,       // Held type.
    output logic                                  hold_burst       // Held burst.
);
    import lbsp_pkg::*;

    // ------------------------------------------------------------------
    // Capture on every transfer start
    // ------------------------------------------------------------------
    // Capture is unconditional so the decode path adds no logic here.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hold_addr  <= '0;
            hold_size  <= '0;
            hold_type  <= '0;
            hold_burst <= 1'b0;
        end else if (!transfer_start_n) begin
            hold_addr  <= addr;
            hold_size  <= transfer_size;
            hold_type  <= transfer_type;
            hold_burst <= !transfer_burst_n;
        end
    end

endmodule

//--- src/lbsp_top.sv
// Local bus slave port: claims, stores and completes split-tenure cycles.
// Assumes bus pins are synchronous to clock; a back end serves each beat.
//
// Overview of operation
// - Drive the claim sideband during the address phase of a targeted cycle.
// - Assert transfer acknowledge to complete each claimed read or write beat.
// - Never request or start bus transactions; only respond to masters.
// - Capture and hold address, size and type of the cycle being served.
// - Accept a pipelined transfer start during data without losing either.
// - No snooping; no cached data supplied, nothing invalidated.
// - Accept burst transfers as well as single beats.
// - Shared outputs like acknowledge are released so others can drive them.
// - Unshared outputs like the claim use forcing levels.
// - Claim goes to the bridge; the bridge returns a data grant.
// - Claim when transfer start is low and top address bits are 001.
// - Hold the claim each clock until address acknowledge; reset clears it.
// - Drive the data bus only for a decoded and claimed cycle.
// - Capture tenure information on every transfer start.
`timescale 1ns/10ps
module lbsp_top (
    input  wire logic                             clock,             // Bus clock.
    input  wire logic                             rst_n,             // Reset.
    input  wire logic                             transfer_start_n,  // Start.
    input  wire logic [lbsp_pkg::ADDR_WIDTH-1:0]  addr,              // Address.
    input  wire logic [lbsp_pkg::SIZE_WIDTH-1:0]  transfer_size,     // Size.
    input  wire logic [lbsp_pkg::TYPE_WIDTH-1:0]  transfer_type,     // Type.
    input  wire logic                             transfer_burst_n,  // Burst.
    input  wire logic                             address_ack_n,     // Addr ack.
    input  wire logic                             slave_data_grant_n, // Grant.
    output logic                                  local_slave_n,     // Claim.
    input  wire logic                             transfer_acknowledge_n_in,
    output logic                                  transfer_acknowledge_n_out,
    output logic                                  transfer_acknowledge_n_oe,
    input  wire logic [lbsp_pkg::DATA_WIDTH-1:0]  data_in,           // Bus data.
    output logic [lbsp_pkg::DATA_WIDTH-1:0]       data_out,          // Read data.
    output logic                                  data_oe,           // Data drive.
    output logic                                  beat_req,          // Beat wanted.
    output logic                                  beat_write,        // Write beat.
    output logic [lbsp_pkg::ADDR_WIDTH-1:0]       beat_addr,         // Beat addr.
    output logic [lbsp_pkg::SIZE_WIDTH-1:0]       beat_size,         // Beat size.
    output logic [lbsp_pkg::TYPE_WIDTH-1:0]       beat_type,         // Beat type.
    output logic [lbsp_pkg::DATA_WIDTH-1:0]       beat_wdata,        // Write data.
    input  wire logic                             beat_done,         // Beat served.
    input  wire logic [lbsp_pkg::DATA_WIDTH-1:0]  beat_rdata         // Read data.
);
    import lbsp_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Address side
    // ------------------------------------------------------------------
    logic [ADDR_WIDTH-1:0] hold_addr;
    logic [SIZE_WIDTH-1:0] hold_size;
    logic [TYPE_WIDTH-1:0] hold_type;
    logic                  hold_burst;

    lbsp_claim u_claim (
        .clock            (clock),
        .rst_sync_n       (rst_sync_n),
        .transfer_start_n (transfer_start_n),
        .addr_top         (addr[ADDR_WIDTH-1 -: DECODE_WIDTH]),
        .address_ack_n    (address_ack_n),
        .local_slave_n    (local_slave_n)
    );

    lbsp_tenure_hold u_hold (
        .clock            (clock),
        .rst_sync_n       (rst_sync_n),
        .transfer_start_n (transfer_start_n),
        .addr             (addr),
        .transfer_size    (transfer_size),
        .transfer_type    (transfer_type),
        .transfer_burst_n (transfer_burst_n),
        .hold_addr        (hold_addr),
        .hold_size        (hold_size),
        .hold_type        (hold_type),
        .hold_burst       (hold_burst)
    );

    // Write-type transfers have bit 3 of the type field clear.
    function automatic logic is_write(input logic [TYPE_WIDTH-1:0] ttype);
        is_write = !ttype[3];
    endfunction

    // ------------------------------------------------------------------
    // Pending acknowledged tenure
    // ------------------------------------------------------------------
    lbsp_phase_type        phase_reg;
    logic                  pending_reg;
    logic                  start_phase;
    logic                  claim_acked;

    assign claim_acked = !local_slave_n && !address_ack_n;
    assign start_phase = (phase_reg == PHASE_IDLE) && pending_reg
                      && !slave_data_grant_n;

    // A new acknowledge beats a take in the same cycle, so no tenure is lost.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pending_reg <= 1'b0;
        end else if (claim_acked) begin
            pending_reg <= 1'b1;
        end else if (start_phase) begin
            pending_reg <= 1'b0;
        end
    end

    logic [ADDR_WIDTH-1:0] pend_addr_reg;
    logic [SIZE_WIDTH-1:0] pend_size_reg;
    logic [TYPE_WIDTH-1:0] pend_type_reg;
    logic                  pend_burst_reg;

    // The holding register follows every start, so keep the acked tenure.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pend_addr_reg  <= '0;
            pend_size_reg  <= '0;
            pend_type_reg  <= '0;
            pend_burst_reg <= 1'b0;
        end else if (claim_acked) begin
            pend_addr_reg  <= hold_addr;
            pend_size_reg  <= hold_size;
            pend_type_reg  <= hold_type;
            pend_burst_reg <= hold_burst;
        end
    end

    // ------------------------------------------------------------------
    // Active data tenure
    // ------------------------------------------------------------------
    logic [ADDR_WIDTH-1:0] active_addr_reg;
    logic [SIZE_WIDTH-1:0] active_size_reg;
    logic [TYPE_WIDTH-1:0] active_type_reg;
    logic                  active_burst_reg;
    logic [BEAT_WIDTH-1:0] beat_count_reg;
    logic                  last_beat;

    // The address pins may already carry a newer tenure; use stored copies.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            active_addr_reg  <= '0;
            active_size_reg  <= '0;
            active_type_reg  <= '0;
            active_burst_reg <= 1'b0;
        end else if (start_phase) begin
            active_addr_reg  <= pend_addr_reg;
            active_size_reg  <= pend_size_reg;
            active_type_reg  <= pend_type_reg;
            active_burst_reg <= pend_burst_reg;
        end
    end

    assign last_beat = !active_burst_reg
                    || beat_count_reg == BEAT_WIDTH'(BURST_BEATS - 1);

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            beat_count_reg <= '0;
        end else if (start_phase) begin
            beat_count_reg <= '0;
        end else if (phase_reg == PHASE_ACK) begin
            beat_count_reg <= beat_count_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Data phase sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            phase_reg <= PHASE_IDLE;
        end else begin
            unique case (phase_reg)
                PHASE_IDLE: begin
                    if (start_phase) begin
                        phase_reg <= PHASE_BEAT;
                    end
                end
                PHASE_BEAT: begin
                    if (beat_done) begin
                        phase_reg <= PHASE_ACK;
                    end
                end
                PHASE_ACK: begin
                    phase_reg <= last_beat ? PHASE_RELEASE : PHASE_BEAT;
                end
                PHASE_RELEASE: begin
                    phase_reg <= PHASE_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------------
    logic [DATA_WIDTH-1:0] rdata_reg;
    logic [DATA_WIDTH-1:0] wdata_reg;

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_reg <= '0;
        end else if (phase_reg == PHASE_BEAT && beat_done) begin
            rdata_reg <= beat_rdata;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdata_reg <= '0;
        end else begin
            wdata_reg <= data_in;
        end
    end

    // Acknowledge is low for one cycle per beat; after the last beat it is driven high
    // for one cycle before release so the shared line is left precharged.
    assign transfer_acknowledge_n_out = (phase_reg != PHASE_ACK);
    assign transfer_acknowledge_n_oe  = (phase_reg == PHASE_ACK)
                                     || (phase_reg == PHASE_RELEASE);
    assign data_out = rdata_reg;
    assign data_oe  = (phase_reg == PHASE_ACK)
                   && !is_write(active_type_reg);

    // The port has no bus request output; it only answers cycles.
    assign beat_req   = (phase_reg == PHASE_BEAT);
    assign beat_write = is_write(active_type_reg);
    assign beat_addr  = {active_addr_reg[ADDR_WIDTH-1:BEAT_LSB+BEAT_WIDTH],
                         active_addr_reg[BEAT_LSB +: BEAT_WIDTH]
                             + beat_count_reg,
                         active_addr_reg[BEAT_LSB-1:0]};
    assign beat_size  = active_size_reg;
    assign beat_type  = active_type_reg;
    assign beat_wdata = wdata_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_sync_n);

    AST_CLAIM_DECODE: assert property (
        !transfer_start_n && addr[ADDR_WIDTH-1 -: DECODE_WIDTH] == DECODE_MATCH
        |=> !local_slave_n)
        else $error("claim missing for decoded cycle");
    AST_CLAIM_HOLD: assert property (
        !local_slave_n && address_ack_n |=> !local_slave_n)
        else $error("claim dropped before address acknowledge");
    AST_HOLD_CAPTURE: assert property (
        !transfer_start_n |=> hold_addr == $past(addr))
        else $error("tenure not captured on transfer start");
    AST_ACTIVE_STABLE: assert property (
        phase_reg != PHASE_IDLE |=> $stable(active_addr_reg))
        else $error("active address changed during data phase");
    AST_START_GATED: assert property (
        phase_reg == PHASE_IDLE ##1 phase_reg == PHASE_BEAT
        |-> $past(!slave_data_grant_n) && $past(pending_reg))
        else $error("data phase started without grant and ack");
    AST_ACK_PULSE: assert property (
        !transfer_acknowledge_n_out |-> transfer_acknowledge_n_oe
        ##1 transfer_acknowledge_n_out)
        else $error("acknowledge not a single driven pulse");
    AST_SINGLE_BEAT: assert property (
        phase_reg == PHASE_ACK && !active_burst_reg
        |=> phase_reg == PHASE_RELEASE ##1 phase_reg == PHASE_IDLE)
        else $error("single beat did not release");
    AST_PIPE_KEEP: assert property (
        (pending_reg || claim_acked) && phase_reg != PHASE_IDLE
        |=> pending_reg)
        else $error("pipelined tenure lost");
    AST_DATA_OWNED: assert property (
        data_oe |-> phase_reg == PHASE_ACK && !beat_write)
        else $error("data bus driven outside a claimed read");
    AST_RELEASE_HIGH: assert property (
        phase_reg == PHASE_RELEASE |-> transfer_acknowledge_n_oe
        && transfer_acknowledge_n_out ##1 !transfer_acknowledge_n_oe)
        else $error("acknowledge not precharged and released");

    COV_SINGLE: cover property (
        start_phase && !pend_burst_reg ##[1:20] phase_reg == PHASE_RELEASE);
    COV_BURST: cover property (
        phase_reg == PHASE_ACK && active_burst_reg && last_beat);
    COV_PIPELINED: cover property (
        claim_acked && phase_reg != PHASE_IDLE);

endmodule

//--- testbench/lbsp_bridge_model.sv
// Host bridge model: ends address phases and grants the data bus.
// Assumes bus inputs change just after rising edges of clock.
`timescale 1ns/10ps
module lbsp_bridge_model (
    input  wire logic       clock,                  // Bus clock.
    input  wire logic       rst_n,                  // Reset.
    input  wire logic       transfer_start_n,       // Start.
    input  wire logic       transfer_burst_n,       // Burst.
    input  wire logic       local_slave_n,          // Claim.
    input  wire logic       transfer_acknowledge_n, // Shared ack level.
    input  wire logic [3:0] grant_delay,            // Grant latency.
    output logic            address_ack_n,          // Address ack.
    output logic            slave_data_grant_n      // Data grant.
);
    logic       want_reg;
    logic       seen_reg;
    logic       burst_reg;
    logic [2:0] beats_reg;
    logic [3:0] wait_reg;
    logic       tenure_free;

    assign tenure_free = beats_reg == 3'h0
                      || (beats_reg == 3'h1 && !transfer_acknowledge_n);

    // ----------------------------------------------------------------
    // Address termination and data tenure tracking
    // ----------------------------------------------------------------
    // A claimed address waits for the running data tenure to finish.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            want_reg      <= 1'b0;
            seen_reg      <= 1'b0;
            burst_reg     <= 1'b0;
            beats_reg     <= 3'h0;
            address_ack_n <= 1'b1;
        end else begin
            address_ack_n <= 1'b1;
            if (!transfer_acknowledge_n && beats_reg != 3'h0) begin
                beats_reg <= beats_reg - 3'h1;
            end
            if (!transfer_start_n) begin
                want_reg  <= 1'b1;
                seen_reg  <= 1'b0;
                burst_reg <= !transfer_burst_n;
            end else if (want_reg && !seen_reg) begin
                seen_reg <= 1'b1;
            end else if (want_reg && (local_slave_n || tenure_free)) begin
                address_ack_n <= 1'b0;
                want_reg      <= 1'b0;
                if (!local_slave_n) begin
                    beats_reg <= burst_reg ? 3'h4 : 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg           <= 4'h0;
            slave_data_grant_n <= 1'b1;
        end else if (beats_reg == 3'h0) begin
            wait_reg           <= 4'h0;
            slave_data_grant_n <= 1'b1;
        end else if (wait_reg >= grant_delay) begin
            slave_data_grant_n <= 1'b0;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule

//--- testbench/local_bus_slave_port_bench.sv
// Self-checking bench for the local bus slave port with a bridge model.
// Assumes the package, port top and bridge model are compiled first.
`timescale 1ns/10ps
module local_bus_slave_port_bench;
    import lbsp_pkg::*;
    typedef struct packed {
        logic [ADDR_WIDTH-1:0] a;
        logic [SIZE_WIDTH-1:0] s;
        logic [TYPE_WIDTH-1:0] t;
        logic                  w;
    } lbsp_beat_type;
    typedef struct packed {
        logic                  rd;
        logic [DATA_WIDTH-1:0] d;
    } lbsp_ack_type;
    localparam logic [31:0] EDGE_ADDR [4] = '{32'h1FFF_FFF8, 32'h2000_0000,
                                              32'h3FFF_FFF8, 32'h4000_0000};

    logic clock, rst_n, transfer_start_n, transfer_burst_n, beat_done;
    logic address_ack_n, slave_data_grant_n, local_slave_n, ack_wire;
    logic ack_out, ack_oe, data_oe, beat_req, beat_write;
    logic [3:0]            grant_delay;
    logic [ADDR_WIDTH-1:0] addr, beat_addr, rnd_addr;
    logic [SIZE_WIDTH-1:0] transfer_size, beat_size;
    logic [TYPE_WIDTH-1:0] transfer_type, beat_type;
    logic [DATA_WIDTH-1:0] data_in, data_out, beat_wdata, beat_rdata, din_hold;
    lbsp_beat_type         beat_q[$];
    lbsp_beat_type         exp_b;
    lbsp_ack_type          ack_q[$];
    lbsp_ack_type          exp_a;
    int                    err_count;
    int                    check_count;

    // The shared acknowledge line has a pull-up when nobody drives it.
    assign ack_wire = ack_oe ? ack_out : 1'b1;

    lbsp_top u_dut (
        .clock(clock), .rst_n(rst_n), .transfer_start_n(transfer_start_n),
        .addr(addr), .transfer_size(transfer_size),
        .transfer_type(transfer_type), .transfer_burst_n(transfer_burst_n),
        .address_ack_n(address_ack_n), .slave_data_grant_n(slave_data_grant_n),
        .local_slave_n(local_slave_n), .transfer_acknowledge_n_in(ack_wire),
        .transfer_acknowledge_n_out(ack_out),
        .transfer_acknowledge_n_oe(ack_oe), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .beat_req(beat_req),
        .beat_write(beat_write), .beat_addr(beat_addr), .beat_size(beat_size),
        .beat_type(beat_type), .beat_wdata(beat_wdata), .beat_done(beat_done),
        .beat_rdata(beat_rdata)
    );

    lbsp_bridge_model u_bridge (
        .clock(clock), .rst_n(rst_n), .transfer_start_n(transfer_start_n),
        .transfer_burst_n(transfer_burst_n), .local_slave_n(local_slave_n),
        .transfer_acknowledge_n(ack_wire), .grant_delay(grant_delay),
        .address_ack_n(address_ack_n), .slave_data_grant_n(slave_data_grant_n)
    );

    // ----------------------------------------------------------------
    // Compare, reset and bus tasks
    // ----------------------------------------------------------------
    task automatic cmp_word(input logic [DATA_WIDTH-1:0] got,
                            input logic [DATA_WIDTH-1:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask

    task automatic cmp_beat(input lbsp_beat_type got, input lbsp_beat_type exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t beat attributes", $time);
        end
    endtask

    task automatic stop_test;
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        beat_q.delete();
        ack_q.delete();
        repeat (3) @(posedge clock);
        cmp_word({local_slave_n, ack_out, ack_oe, data_oe, beat_req}, 5'b11000,
                 "reset state");
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask

    // Issues one start; returns at the edge where address ack is seen.
    task automatic bus_cycle(input logic [ADDR_WIDTH-1:0] a,
                             input logic burst, input logic wr);
        logic          hit;
        lbsp_beat_type b;
        hit = (a[31:29] == DECODE_MATCH);
        b.s = SIZE_WIDTH'($urandom);
        b.t = TYPE_WIDTH'($urandom);
        b.t[3] = !wr;
        b.w = wr;
        transfer_start_n <= 1'b0;
        addr             <= a;
        transfer_size    <= b.s;
        transfer_type    <= b.t;
        transfer_burst_n <= !burst;
        grant_delay      <= 4'($urandom_range(6));
        for (int k = 0; k < (burst ? BURST_BEATS : 1) && hit; k++) begin
            b.a = {a[31:5], a[4:3] + 2'(k), a[2:0]};
            beat_q.push_back(b);
        end
        @(posedge clock);
        transfer_start_n <= 1'b1;
        addr             <= $urandom;
        transfer_type    <= ~b.t;
        transfer_burst_n <= burst;
        @(posedge clock);
        #1 cmp_word(local_slave_n, !hit, "claim");
        for (int i = 0; i < 300 && address_ack_n !== 1'b0; i++) begin
            if (hit) cmp_word(local_slave_n, 1'b0, "claim held");
            @(posedge clock);
        end
        cmp_word(address_ack_n, 1'b0, "address ack wait");
    endtask

    // ----------------------------------------------------------------
    // Stimulus, back end, watcher and watchdog
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) data_in <= {$urandom, $urandom};

    initial begin
        beat_done  = 1'b0;
        beat_rdata = '0;
        forever begin
            @(posedge clock);
            if (beat_req === 1'b1 && rst_n === 1'b1) begin
                repeat ($urandom_range(3)) @(posedge clock);
                beat_done  <= 1'b1;
                beat_rdata <= {$urandom, $urandom};
                @(posedge clock);
                beat_done  <= 1'b0;
                beat_rdata <= ~beat_rdata;
            end
        end
    end

    always @(negedge clock) begin
        if (rst_n === 1'b1) begin
            if (beat_req === 1'b1) cmp_word(slave_data_grant_n, 1'b0, "grant");
            if (beat_req === 1'b1 && beat_done === 1'b1) begin
                if (beat_q.size() == 0) begin
                    cmp_word(1'b1, 1'b0, "unexpected beat");
                end else begin
                    exp_b = beat_q.pop_front();
                    cmp_beat({beat_addr, beat_size, beat_type, beat_write}, exp_b);
                    if (exp_b.w) cmp_word(beat_wdata, din_hold, "write data");
                    ack_q.push_back(lbsp_ack_type'{!exp_b.w, beat_rdata});
                end
            end
            if (ack_wire === 1'b0) begin
                if (ack_q.size() == 0) begin
                    cmp_word(1'b1, 1'b0, "unexpected ack");
                end else begin
                    exp_a = ack_q.pop_front();
                    cmp_word(data_oe, exp_a.rd, "data drive");
                    if (exp_a.rd) cmp_word(data_out, exp_a.d, "read data");
                end
            end else begin
                cmp_word(data_oe, 1'b0, "idle data drive");
            end
        end
        din_hold = data_in;
    end

    initial begin
        repeat (30000) @(posedge clock);
        err_count++;
        $display("MISMATCH %0t timeout", $time);
        stop_test();
    end

    initial begin
        void'($urandom(32'hD8D55CE6));
        err_count = 0;
        check_count = 0;
        {rst_n, transfer_start_n, transfer_burst_n} = 3'b011;
        {addr, transfer_size, transfer_type, grant_delay} = '0;
        data_in = '0;
        din_hold = '0;
        @(posedge clock);
        do_reset();
        for (int i = 0; i < 4; i++) bus_cycle(EDGE_ADDR[i], i[0], i[1]);
        bus_cycle(32'h2000_0100, 1'b0, 1'b1);
        bus_cycle(32'h5000_0000, 1'b0, 1'b1);
        repeat (30) begin
            rnd_addr = $urandom;
            if ($urandom_range(3) != 0) rnd_addr[31:29] = DECODE_MATCH;
            bus_cycle(rnd_addr, 1'($urandom), 1'($urandom));
        end
        for (int i = 0; i < 500 && beat_q.size() + ack_q.size() != 0; i++)
            @(posedge clock);
        cmp_word(64'(beat_q.size() + ack_q.size()), '0, "drain");
        bus_cycle(32'h2000_0040, 1'b1, 1'b0);
        for (int i = 0; i < 50 && beat_req !== 1'b1; i++) @(posedge clock);
        do_reset();
        bus_cycle(32'h3000_0008, 1'b0, 1'b1);
        for (int i = 0; i < 100 && beat_q.size() + ack_q.size() != 0; i++)
            @(posedge clock);
        repeat (4) @(posedge clock);
        cmp_word(64'(beat_q.size() + ack_q.size()), '0, "final drain");
        stop_test();
    end
endmodule
